// [verilog/tpwm_consts.svh]
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TPWM_OFF_CTRL      8'h00
`define TPWM_OFF_COUNT     8'h04
`define TPWM_OFF_CMPA      8'h08
`define TPWM_OFF_CMPB      8'h0C
`define TPWM_OFF_CAPT      8'h10
`define TPWM_OFF_FLAGS     8'h14

// ****************************************
// reset values
// ****************************************
`define TPWM_RST_CTRL      16'h0000
`define TPWM_RST_WORD      16'h0000
`define TPWM_RST_FLAGS     4'h0

// ****************************************
// flag register bit positions
// ****************************************
`define TPWM_FLAG_OVF      0
`define TPWM_FLAG_CMPA     1
`define TPWM_FLAG_CMPB     2
`define TPWM_FLAG_CAPT     3

// ****************************************
// fixed top and bottom values
// ****************************************
`define TPWM_TOP_8BIT      16'h00FF
`define TPWM_TOP_9BIT      16'h01FF
`define TPWM_TOP_10BIT     16'h03FF
`define TPWM_MAX           16'hFFFF
`define TPWM_BOTTOM        16'h0000

// ****************************************
// waveform mode select codes
// ****************************************
`define TPWM_MODE_PC8      4'h1
`define TPWM_MODE_PC9      4'h2
`define TPWM_MODE_PC10     4'h3
`define TPWM_MODE_FAST8    4'h5
`define TPWM_MODE_FAST9    4'h6
`define TPWM_MODE_FAST10   4'h7
`define TPWM_MODE_PC_CAPT  4'hA
`define TPWM_MODE_PC_CMPA  4'hB
`define TPWM_MODE_FAST_CAPT 4'hE
`define TPWM_MODE_FAST_CMPA 4'hF

// ****************************************
// compare output select codes
// ****************************************
`define TPWM_COM_OFF       2'h0
`define TPWM_COM_TOGGLE    2'h1
`define TPWM_COM_NONINV    2'h2
`define TPWM_COM_INV       2'h3

// ****************************************
// prescaler selects: stop, 1, 8, 64, 256, 1024
// ****************************************
`define TPWM_CS_1          3'h1
`define TPWM_CS_8          3'h2
`define TPWM_CS_64         3'h3
`define TPWM_CS_256        3'h4
`define TPWM_CS_1024       3'h5

`endif

// [verilog/tpwm_pkg.sv]
`default_nettype none
package tpwm_pkg;

    typedef struct packed {
        logic       dir_b;
        logic       dir_a;
        logic       route_b;
        logic       route_a;
        logic       rsv;
        logic [2:0] clk_sel;
        logic [1:0] com_b;
        logic [1:0] com_a;
        logic [3:0] mode;
    } tpwm_ctrl_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } tpwm_pin_t;

    typedef enum logic {
        TPWM_UP,
        TPWM_DOWN
    } tpwm_dir_t;

endpackage
`default_nettype wire

// [verilog/tpwm_timer16.sv]
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_consts.svh"

module tpwm_timer16 (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    output var tpwm_pkg::tpwm_pin_t pin_a,
    output var tpwm_pkg::tpwm_pin_t pin_b
);
    import tpwm_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    function automatic logic is_fast(input logic [3:0] m);
        is_fast = (m == `TPWM_MODE_FAST8) || (m == `TPWM_MODE_FAST9) || (m == `TPWM_MODE_FAST10) ||
                  (m == `TPWM_MODE_FAST_CAPT) || (m == `TPWM_MODE_FAST_CMPA);
    endfunction

    function automatic logic is_pc(input logic [3:0] m);
        is_pc = (m == `TPWM_MODE_PC8) || (m == `TPWM_MODE_PC9) || (m == `TPWM_MODE_PC10) ||
                (m == `TPWM_MODE_PC_CAPT) || (m == `TPWM_MODE_PC_CMPA);
    endfunction

    // fixed-width mask; all ones when top is not fixed
    function automatic logic [15:0] width_mask(input logic [3:0] m);
        case (m)
            `TPWM_MODE_PC8, `TPWM_MODE_FAST8:   width_mask = `TPWM_TOP_8BIT;
            `TPWM_MODE_PC9, `TPWM_MODE_FAST9:   width_mask = `TPWM_TOP_9BIT;
            `TPWM_MODE_PC10, `TPWM_MODE_FAST10: width_mask = `TPWM_TOP_10BIT;
            default:                            width_mask = `TPWM_MAX;
        endcase
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] capt,
                                           input logic [15:0] cmpa);
        case (m)
            `TPWM_MODE_PC_CAPT, `TPWM_MODE_FAST_CAPT: top_of = capt;
            `TPWM_MODE_PC_CMPA, `TPWM_MODE_FAST_CMPA: top_of = cmpa;
            default:                                  top_of = width_mask(m);
        endcase
    endfunction

    function automatic logic presc_tick(input logic [2:0] sel, input logic [9:0] p);
        case (sel)
            `TPWM_CS_1:    presc_tick = 1'b1;
            `TPWM_CS_8:    presc_tick = &p[2:0];
            `TPWM_CS_64:   presc_tick = &p[5:0];
            `TPWM_CS_256:  presc_tick = &p[7:0];
            `TPWM_CS_1024: presc_tick = &p[9:0];
            default:       presc_tick = 1'b0;
        endcase
    endfunction

    // next compare output state; match wins over the top action so compare==top stays constant
    function automatic logic next_oc(input logic cur, input logic [1:0] com, input logic fast,
                                     input logic pc, input logic match, input logic top_evt,
                                     input logic going_up, input logic chan_a);
        next_oc = cur;
        if (fast) begin
            case (com)
                `TPWM_COM_TOGGLE: next_oc = (chan_a && match) ? ~cur : cur;
                `TPWM_COM_NONINV: next_oc = match ? 1'b1 : (top_evt ? 1'b0 : cur);
                `TPWM_COM_INV:    next_oc = match ? 1'b0 : (top_evt ? 1'b1 : cur);
                default:          next_oc = cur;
            endcase
        end else if (pc) begin
            case (com)
                `TPWM_COM_NONINV: next_oc = match ? ~going_up : cur;
                `TPWM_COM_INV:    next_oc = match ? going_up : cur;
                default:          next_oc = cur;
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    tpwm_ctrl_t  ctrl;
    logic [9:0]  presc;
    logic [15:0] counter_value;
    tpwm_dir_t   dir;
    logic [15:0] compare_active_a;
    logic [15:0] compare_active_b;
    logic [15:0] compare_buf_a;
    logic [15:0] compare_buf_b;
    logic [15:0] capture_register;
    logic [3:0]  flags;
    logic        oc_a;
    logic        oc_b;
    logic        wr_pend;
    logic [7:0]  wr_addr;

    logic        tick;
    logic        fast;
    logic        pc;
    logic [15:0] top_value;
    logic        at_top;
    logic        at_bottom;
    logic        going_up;
    logic        match_a;
    logic        match_b;
    logic        fast_top_evt;
    logic        load_evt;
    logic        top_capt;
    logic        top_cmpa;
    logic [15:0] wmask;
    logic        wr_ctrl;
    logic        wr_cmpa;
    logic        wr_cmpb;
    logic        wr_capt;
    logic        wr_flags;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;

    assign tick         = presc_tick(ctrl.clk_sel, presc);
    assign fast         = is_fast(ctrl.mode);
    assign pc           = is_pc(ctrl.mode);
    assign top_value    = top_of(ctrl.mode, capture_register, compare_active_a);
    assign at_top       = (counter_value == top_value);
    assign at_bottom    = (counter_value == `TPWM_BOTTOM);
    assign going_up     = at_bottom || ((dir == TPWM_UP) && !at_top);
    assign match_a      = (counter_value == compare_active_a);
    assign match_b      = (counter_value == compare_active_b);
    assign fast_top_evt = tick && fast && at_top;
    assign load_evt     = fast_top_evt || (tick && pc && (dir == TPWM_UP) && at_top);
    assign top_capt     = (ctrl.mode == `TPWM_MODE_PC_CAPT) || (ctrl.mode == `TPWM_MODE_FAST_CAPT);
    assign top_cmpa     = (ctrl.mode == `TPWM_MODE_PC_CMPA) || (ctrl.mode == `TPWM_MODE_FAST_CMPA);
    assign wmask        = width_mask(ctrl.mode);

    // ****************************************
    // ahb-lite slave, zero wait states
    // ****************************************
    assign wr_ctrl  = wr_pend && (wr_addr == `TPWM_OFF_CTRL);
    assign wr_cmpa  = wr_pend && (wr_addr == `TPWM_OFF_CMPA);
    assign wr_cmpb  = wr_pend && (wr_addr == `TPWM_OFF_CMPB);
    assign wr_capt  = wr_pend && (wr_addr == `TPWM_OFF_CAPT);
    assign wr_flags = wr_pend && (wr_addr == `TPWM_OFF_FLAGS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // read data sampled in the address phase, so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `TPWM_OFF_CTRL:  hrdata <= {16'h0000, ctrl};
                `TPWM_OFF_COUNT: hrdata <= {16'h0000, counter_value};
                `TPWM_OFF_CMPA:  hrdata <= {16'h0000, compare_buf_a};
                `TPWM_OFF_CMPB:  hrdata <= {16'h0000, compare_buf_b};
                `TPWM_OFF_CAPT:  hrdata <= {16'h0000, capture_register};
                `TPWM_OFF_FLAGS: hrdata <= {26'h000_0000, oc_b, oc_a, flags};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `TPWM_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl     <= hwdata[15:0];
            ctrl.rsv <= 1'b0;
        end
    end

    // ****************************************
    // prescaler and counter
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc <= 10'h000;
        end else if (ctrl.clk_sel == 3'h0) begin
            presc <= 10'h000;
        end else begin
            presc <= presc + 10'h001;
        end
    end

    // a capture top written below the count is missed and the counter wraps through max
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_value <= `TPWM_RST_WORD;
            dir           <= TPWM_UP;
        end else if (tick) begin
            if (fast) begin
                dir           <= TPWM_UP;
                counter_value <= at_top ? `TPWM_BOTTOM : counter_value + 16'h0001;
            end else if (pc) begin
                if (dir == TPWM_UP && at_top) begin
                    dir           <= TPWM_DOWN;
                    counter_value <= counter_value - 16'h0001;
                end else if (dir == TPWM_DOWN && at_bottom) begin
                    dir           <= TPWM_UP;
                    counter_value <= counter_value + 16'h0001;
                end else if (dir == TPWM_UP) begin
                    counter_value <= counter_value + 16'h0001;
                end else begin
                    counter_value <= counter_value - 16'h0001;
                end
            end else begin
                dir           <= TPWM_UP;
                counter_value <= counter_value + 16'h0001;
            end
        end
    end

    // ****************************************
    // compare and capture registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_buf_a    <= `TPWM_RST_WORD;
            compare_active_a <= `TPWM_RST_WORD;
        end else begin
            if (wr_cmpa) begin
                compare_buf_a <= hwdata[15:0] & wmask;
            end
            if (wr_cmpa && !fast && !pc) begin
                compare_active_a <= hwdata[15:0] & wmask;
            end else if (load_evt) begin
                compare_active_a <= compare_buf_a;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_buf_b    <= `TPWM_RST_WORD;
            compare_active_b <= `TPWM_RST_WORD;
        end else begin
            if (wr_cmpb) begin
                compare_buf_b <= hwdata[15:0] & wmask;
            end
            if (wr_cmpb && !fast && !pc) begin
                compare_active_b <= hwdata[15:0] & wmask;
            end else if (load_evt) begin
                compare_active_b <= compare_buf_b;
            end
        end
    end

    // unbuffered on purpose: takes effect on the very next compare
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_register <= `TPWM_RST_WORD;
        end else if (wr_capt) begin
            capture_register <= hwdata[15:0];
        end
    end

    // ****************************************
    // flags, write one to clear, set wins
    // ****************************************
    always_comb begin
        flag_set                  = 4'h0;
        flag_set[`TPWM_FLAG_OVF]  = fast_top_evt || (tick && pc && dir == TPWM_DOWN && at_bottom) ||
                                    (tick && !fast && !pc && counter_value == `TPWM_MAX);
        flag_set[`TPWM_FLAG_CMPA] = tick && match_a;
        flag_set[`TPWM_FLAG_CMPB] = tick && match_b;
        flag_set[`TPWM_FLAG_CAPT] = load_evt && top_capt;
        flag_clr                  = wr_flags ? hwdata[3:0] : 4'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= `TPWM_RST_FLAGS;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // ****************************************
    // waveform outputs and pins
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_a <= 1'b0;
            oc_b <= 1'b0;
        end else if (tick) begin
            oc_a <= next_oc(oc_a, ctrl.com_a, fast, pc, match_a, at_top, going_up, 1'b1);
            oc_b <= next_oc(oc_b, ctrl.com_b, fast, pc, match_b, at_top, going_up, 1'b0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_a <= '{out: 1'b0, oe_n: 1'b1};
            pin_b <= '{out: 1'b0, oe_n: 1'b1};
        end else begin
            pin_a.out  <= oc_a && ctrl.dir_a && ctrl.route_a;
            pin_a.oe_n <= !(ctrl.dir_a && ctrl.route_a);
            pin_b.out  <= oc_b && ctrl.dir_b && ctrl.route_b;
            pin_b.oe_n <= !(ctrl.dir_b && ctrl.route_b);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fast_top;
        tick && fast && at_top;
    endsequence

    sequence s_pc_top;
        tick && pc && (dir == TPWM_UP) && at_top;
    endsequence

    sequence s_pc_bottom;
        tick && pc && (dir == TPWM_DOWN) && at_bottom;
    endsequence

    a_fast_wrap: assert property (s_fast_top |=> counter_value == `TPWM_BOTTOM)
        else $error("fast counter not cleared after top");
    a_fast_count: assert property (tick && fast && !at_top |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("fast counter did not increment");
    a_fast_ovf: assert property (s_fast_top |=> flags[`TPWM_FLAG_OVF])
        else $error("overflow flag missing at fast top");
    a_fast_capt_flag: assert property (s_fast_top ##0 top_capt |=> flags[`TPWM_FLAG_CAPT])
        else $error("capture flag missing at fast top");
    a_fast_load: assert property (s_fast_top |=> compare_active_a == $past(compare_buf_a))
        else $error("compare A not loaded at fast top");
    a_fast_set: assert property (tick && fast && ctrl.com_a == `TPWM_COM_NONINV && match_a |=> oc_a)
        else $error("non-inverting output not set on match");
    a_fast_toggle: assert property (tick && fast && ctrl.com_a == `TPWM_COM_TOGGLE && match_a
        |=> oc_a != $past(oc_a))
        else $error("toggle missing on match");
    a_pc_turn: assert property (s_pc_top |=> dir == TPWM_DOWN
        && counter_value == $past(counter_value) - 16'h0001)
        else $error("phase correct did not reverse at top");
    a_pc_ovf: assert property (s_pc_bottom |=> flags[`TPWM_FLAG_OVF] && dir == TPWM_UP)
        else $error("overflow flag missing at bottom");
    a_pc_load_b: assert property (s_pc_top |=> compare_active_b == $past(compare_buf_b))
        else $error("compare B not loaded at top");
    a_pc_clear_up: assert property (tick && pc && ctrl.com_a == `TPWM_COM_NONINV && match_a
        && going_up |=> !oc_a)
        else $error("output not cleared on up match");
    a_cmp_flag_b: assert property (tick && (fast || pc) && match_b |=> flags[`TPWM_FLAG_CMPB])
        else $error("compare B flag missing");
    a_com_off: assert property (ctrl.com_b == `TPWM_COM_OFF |=> $stable(oc_b))
        else $error("output changed with select zero");
    a_hold_notick: assert property (!tick |=> $stable(counter_value) && $stable(dir))
        else $error("counter moved without tick");
    a_pin_route: assert property (!(ctrl.dir_a && ctrl.route_a) |=> pin_a.oe_n && !pin_a.out)
        else $error("pin driven without direction and route");
    a_mask_fixed: assert property (wr_cmpa && wmask != `TPWM_MAX |=> (compare_buf_a & ~$past(wmask)) == 16'h0000)
        else $error("unused compare bits not masked");

endmodule // tpwm_timer16
`default_nettype wire

// [verilog/tpwm_pkg_order_note.sv]
`default_nettype none
`default_nettype wire

// [tb/tpwm_timer16_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_consts.svh"

module tpwm_timer16_test;
    import tpwm_pkg::*;

    // ****************************************
    // bench signals
    // ****************************************
    typedef struct {
        logic [3:0]  mode;
        logic [1:0]  com;
        logic [2:0]  cs;
        logic [15:0] cmp;
        int          m;
        int          hi;
        int          rise;
    } tpwm_case_t;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    tpwm_pin_t   pin_a;
    tpwm_pin_t   pin_b;
    int          err_count;
    int          n_compared;
    logic [31:0] rd;

    // capture top is 7 for modes A/E; windows span whole periods so phase drops out
    tpwm_case_t tbl [15] = '{
        '{4'hE, 2'h2, 3'h1, 16'h0002, 16, 10, 2}, '{4'hE, 2'h3, 3'h1, 16'h0002, 16, 6, 2},
        '{4'hE, 2'h2, 3'h2, 16'h0002, 128, 80, 2}, '{4'hE, 2'h2, 3'h3, 16'h0002, 1024, 640, 2},
        '{4'hE, 2'h2, 3'h1, 16'h0000, 16, 14, 2}, '{4'hE, 2'h2, 3'h1, 16'h0007, 16, 16, 0},
        '{4'hE, 2'h0, 3'h1, 16'h0002, 16, 16, 0}, '{4'hE, 2'h1, 3'h1, 16'h0000, 32, 16, 2},
        '{4'hA, 2'h2, 3'h1, 16'h0002, 28, 8, 2}, '{4'hA, 2'h3, 3'h1, 16'h0002, 28, 20, 2},
        '{4'hA, 2'h2, 3'h2, 16'h0002, 224, 64, 2}, '{4'hA, 2'h2, 3'h1, 16'h0000, 28, 0, 0},
        '{4'hA, 2'h2, 3'h1, 16'h0007, 28, 28, 0}, '{4'h5, 2'h2, 3'h1, 16'h0040, 256, 191, 1},
        '{4'h1, 2'h2, 3'h1, 16'h0040, 510, 128, 1}
    };

    tpwm_timer16 dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_a(pin_a), .pin_b(pin_b)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // single word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic window(input int m, input logic chb, output int hi, output int rise);
        logic prev;
        logic now_v;
        hi = 0;
        rise = 0;
        @(posedge hclk);
        prev = chb ? pin_b.out : pin_a.out;
        repeat (m) begin
            @(posedge hclk);
            now_v = chb ? pin_b.out : pin_a.out;
            if (now_v === 1'b1) hi++;
            if (now_v === 1'b1 && prev === 1'b0) rise++;
            prev = now_v;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk(32'(pin_a), 32'h1);
        chk(32'(hresp), 32'h0);
        bus(1'b0, `TPWM_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `TPWM_OFF_COUNT, 32'h55);
        bus(1'b0, `TPWM_OFF_COUNT, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h18, 32'h5A);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_wave();
        tpwm_case_t c;
        int hi;
        int rise;
        bus(1'b1, `TPWM_OFF_CAPT, 32'h7);
        foreach (tbl[i]) begin
            c = tbl[i];
            // control first, so the compare write is masked to the new mode's width and buffered until its top
            bus(1'b1, `TPWM_OFF_CTRL, {16'h0, 4'h5, 1'b0, c.cs, 2'h0, c.com, c.mode});
            bus(1'b1, `TPWM_OFF_CMPA, {16'h0, c.cmp});
            repeat (2 * c.m) @(posedge hclk);
            window(c.m, 1'b0, hi, rise);
            chk(32'(hi), 32'(c.hi));
            chk(32'(rise), 32'(c.rise));
            chk(32'(pin_a.oe_n), 32'h0);
        end
        $display("test waveforms done");
    endtask

    // channel b, inverting, top from compare a
    task automatic t_chan_b();
        int hi;
        int rise;
        // mode 0 with clock stopped loads both compares directly, so the counter starts under top
        bus(1'b1, `TPWM_OFF_CMPA, 32'h7);
        bus(1'b1, `TPWM_OFF_CMPB, 32'h2);
        bus(1'b1, `TPWM_OFF_CTRL, {16'h0, 4'hA, 1'b0, 3'h1, 2'h3, 2'h0, 4'hF});
        repeat (32) @(posedge hclk);
        window(16, 1'b1, hi, rise);
        chk(32'(hi), 32'h6);
        chk(32'(rise), 32'h2);
        chk(32'(pin_b.oe_n), 32'h0);
        bus(1'b0, `TPWM_OFF_FLAGS, 32'h0);
        chk(rd & 32'hF, 32'h7);
        $display("test channel b done");
    endtask

    task automatic t_flags();
        logic [31:0] held;
        bus(1'b1, `TPWM_OFF_CTRL, 32'h1);
        bus(1'b0, `TPWM_OFF_FLAGS, 32'h0);
        chk(rd & 32'hF, 32'hF);
        bus(1'b1, `TPWM_OFF_FLAGS, 32'hF);
        bus(1'b0, `TPWM_OFF_FLAGS, 32'h0);
        chk(rd & 32'hF, 32'h0);
        bus(1'b0, `TPWM_OFF_COUNT, 32'h0);
        held = rd;
        repeat (20) @(posedge hclk);
        bus(1'b0, `TPWM_OFF_COUNT, 32'h0);
        chk(rd, held);
        bus(1'b1, `TPWM_OFF_CMPA, 32'h1234);
        bus(1'b0, `TPWM_OFF_CMPA, 32'h0);
        chk(rd, 32'h34);
        chk(32'(pin_b), 32'h1);
        $display("test flags done");
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        err_count = 0;
        n_compared = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_chan_b();
        t_wave();
        t_flags();
        wrap_up();
    end

    // about 7.3k cycles expected; generous margin before giving up
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        wrap_up();
    end

endmodule // tpwm_timer16_test
`default_nettype wire
